// >>> cfs_top.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - once locked, double_rate_clk and its inverse run at twice the source frequency.
// - divided_clk is source divided by 1.5..8 in halves or 9..16; default 2.
// - synth_clk frequency is source times multiplier over divisor.
// - synth_clk and synth_clk_inverted always have 50/50 duty.
// - synth_clk_inverted is synth_clk shifted half a period.
// - unconfigured multiplier and divisor default to 4 and 1.
// - with feedback, synth rising edge meets source once every divisor cycles.
// - double_rate_clk is 50/50 once locked and absent in loop high-frequency mode.
// - before lock double_rate_clk runs at source rate with 25/75 duty.
// - divided_clk is 50/50 in both loop modes, half ratios included.
// - lock_indicator rises only after the settings are reached.
// - reset drops lock, zeroes taps, keeps multiplier and divisor.
// - in reset all generated clocks hold low.
// - 8-bit status; bit 1 flags source loss, only with feedback connected.
// - status bit 2 flags stopped synth clocks while source runs.
// - synthesizer low range by default; high only when selected (SYNTH_RANGE_SELECT has no effect in the code).
// - optional startup stall in the chosen phase until lock.
module cfs_top
	import cfs_pkg::*;
#(
	parameter logic [5:0]  DIVIDE_HALVES         = DIVIDE_HALVES_DEF,
	parameter logic [5:0]  SYNTH_MULTIPLIER      = MULT_DEF,
	parameter logic [5:0]  SYNTH_DIVISOR         = DIV_DEF,
	parameter bit          SYNTH_RANGE_SELECT    = 1'b0,
	parameter bit          LOOP_HIGH_RANGE       = 1'b0,
	parameter bit          HOLD_STARTUP_FOR_LOCK = 1'b0,
	parameter logic [2:0]  LOCK_WAIT_PHASE       = 3'h6,
	parameter int unsigned SOURCE_PERIOD_HINT_PS = HINT_PS_DEF
) (
	input  wire logic                core_clk,
	input  wire logic                rstn,
	input  wire logic                source_clk,
	input  wire logic                feedback_clk,
	input  wire logic [2:0]          startup_phase,
	output var  logic                zero_phase_clk,
	output var  logic                double_rate_clk,
	output var  logic                double_rate_clk_inverted,
	output var  logic                divided_clk,
	output var  logic                synth_clk,
	output var  logic                synth_clk_inverted,
	output var  logic                lock_indicator,
	output var  logic [STATUS_W-1:0] status,
	output var  logic                startup_stall
);
	// ==================================================
	// helpers
	// quarter(p, n) is n quarters of a period, rounded down; when the
	// period is not a multiple of four the taps land up to one core
	// cycle early, and every shaped output inherits that error
	function automatic logic [PERIOD_W-1:0] quarter(input logic [PERIOD_W-1:0] p,
		input logic [1:0] n);
		logic [PERIOD_W+1:0] prod;
		prod = p * n;
		quarter = prod[PERIOD_W+1:2];
	endfunction

	// distance between two periods, whichever is larger
	function automatic logic [PERIOD_W-1:0] absdiff(input logic [PERIOD_W-1:0] a,
		input logic [PERIOD_W-1:0] b);
		absdiff = (a > b) ? (a - b) : (b - a);
	endfunction

	// hint seeds the period estimate so the synthesizer starts near target
	// a wrong hint only slows the first lock; the estimate is always
	// replaced by the first full measured period
	localparam logic [PERIOD_W-1:0] HINT_CYC =
		PERIOD_W'(SOURCE_PERIOD_HINT_PS / CORE_PERIOD_PS);
	// static settings, fixed at elaboration and untouched by reset
	localparam logic [ACC_W-1:0] FX_STEP = ACC_W'({SYNTH_MULTIPLIER, 1'b0});

	// ==================================================
	// pin synchronisers
	// both clock pins are foreign to core_clk: two flops before any
	// logic, a third for edge detection, so every pin edge is seen
	// two core cycles late; the outputs carry that fixed latency
	// a source that rests high through reset gives one early edge,
	// which only spoils the first, partial period measurement
	logic [1:0] src_sync_q;
	logic [1:0] fb_sync_q;
	logic       src_prev_q;
	logic       fb_prev_q;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			src_sync_q <= 2'h0;
			fb_sync_q  <= 2'h0;
			src_prev_q <= 1'b0;
			fb_prev_q  <= 1'b0;
		end else begin
			src_sync_q <= {src_sync_q[0], source_clk};
			fb_sync_q  <= {fb_sync_q[0], feedback_clk};
			src_prev_q <= src_sync_q[1];
			fb_prev_q  <= fb_sync_q[1];
		end
	end

	wire src_rise = src_sync_q[1] & ~src_prev_q;
	wire fb_rise  = fb_sync_q[1] & ~fb_prev_q;

	// ==================================================
	// period measurement: ph_q is the tap position within a source period
	// resolution is one core cycle, so the source period should span
	// at least four core cycles for the four quarter taps to differ;
	// ph_q saturates so a dead source reads as a very long period
	logic [PERIOD_W-1:0] ph_q;
	logic [PERIOD_W-1:0] period_q;
	logic [5:0]          stable_q;
	logic [1:0]          fb_age_q;
	cfs_lock_type        lock_q;
	cfs_lock_type        lock_d;

	wire [PERIOD_W-1:0] meas      = ph_q + 16'h0001;
	wire                meas_ok   = absdiff(meas, period_q) <= PERIOD_TOL;
	wire [PERIOD_W-1:0] q1        = quarter(period_q, 2'h1);
	wire [PERIOD_W-1:0] q2        = quarter(period_q, 2'h2);
	wire [PERIOD_W-1:0] q3        = quarter(period_q, 2'h3);
	wire                qtr_event = (ph_q == 16'h0000) | (ph_q == q1) |
	                                (ph_q == q2) | (ph_q == q3);
	// lost when no source edge for two expected periods
	wire                src_lost  = ({1'b0, ph_q} > {period_q, 1'b0});
	wire                fb_present = (fb_age_q < 2'h2);

	// taps restart at zero on reset; the period estimate reloads the hint
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ph_q     <= 16'h0000;
			period_q <= HINT_CYC;
			stable_q <= 6'h00;
		end else if (src_rise) begin
			ph_q     <= 16'h0000;
			period_q <= meas;
			stable_q <= (meas_ok && stable_q != LOCK_PERIODS) ? stable_q + 6'h01 :
			            (meas_ok ? stable_q : 6'h00);
		end else begin
			ph_q     <= (ph_q == PERIOD_MAX) ? ph_q : ph_q + 16'h0001;
			stable_q <= src_lost ? 6'h00 : stable_q;
		end
	end

	// feedback counts as connected if seen since the source edge before last
	// the age saturates at two source edges: a grounded feedback pin
	// must look absent, else a stopped source would be misreported
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fb_age_q <= 2'h2;
		end else if (fb_rise) begin
			fb_age_q <= 2'h0;
		end else if (src_rise && fb_age_q != 2'h2) begin
			fb_age_q <= fb_age_q + 2'h1;
		end
	end

	// ==================================================
	// lock tracker
	// idle waits for the first source edge, measure counts matching
	// periods, locked holds until the source goes missing; a lost
	// lock falls back to measure, so recovery needs no fresh reset
	always_comb begin
		lock_d = lock_q;
		case (lock_q)
			CFS_IDLE:    lock_d = src_rise ? CFS_MEASURE : CFS_IDLE;
			// only a run of matching periods counts as reaching the settings
			CFS_MEASURE: lock_d = (stable_q == LOCK_PERIODS) ? CFS_LOCKED : CFS_MEASURE;
			CFS_LOCKED:  lock_d = src_lost ? CFS_MEASURE : CFS_LOCKED;
			default:     lock_d = CFS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lock_q <= CFS_IDLE;
		end else begin
			lock_q <= lock_d;
		end
	end

	// one decoded lock flag feeds both doubled clocks, lock_indicator and startup_stall,
	// so all of them switch from the pre-lock to the locked form on the same core edge
	wire locked = (lock_q == CFS_LOCKED);

	// ==================================================
	// 1x, 2x and divided outputs from tap position
	// the doubled clock is cut from the quarter taps, so its edges
	// carry the same one-cycle rounding as the taps; before lock it
	// is a 1x clock high for the first quarter only
	wire dbl_pre  = (ph_q < q1);
	wire dbl_lock = (ph_q < q1) | ((ph_q >= q2) & (ph_q < q3));
	// inverse is the doubled clock half a doubled period later
	wire dbl_inv  = ((ph_q >= q1) & (ph_q < q2)) | (ph_q >= q3);
	wire dbl_on   = ~LOOP_HIGH_RANGE;

	// divider state: quarter counter and the output level
	logic [5:0] dv_cnt_q;
	logic       dv_q;

	// toggling every DIVIDE_HALVES quarters keeps half ratios at 50/50
	// a half ratio such as 1.5 needs an edge in mid source period,
	// which counting whole periods cannot give but quarter steps can
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dv_cnt_q <= 6'h00;
			dv_q     <= 1'b0;
		end else if (qtr_event && ph_q < period_q) begin
			dv_cnt_q <= (dv_cnt_q == DIVIDE_HALVES - 6'h01) ? 6'h00 : dv_cnt_q + 6'h01;
			dv_q     <= (dv_cnt_q == DIVIDE_HALVES - 6'h01) ? ~dv_q : dv_q;
		end
	end

	// ==================================================
	// synthesizer: accumulator toggles every P*D/(2M) core cycles
	// the step is 2M and the limit P*D, so the remainder carried over
	// each wrap keeps the long-run frequency exact; single edges may
	// sit one core cycle off, which is the limit of this resolution
	// outputs above half the core clock cannot be built this way
	logic [ACC_W-1:0] fx_acc_q;
	logic             fx_q;
	logic [5:0]       fx_dcnt_q;
	logic [ACC_W-1:0] fx_idle_q;

	wire [ACC_W-1:0] fx_limit = ACC_W'(period_q) * ACC_W'(SYNTH_DIVISOR);
	wire [ACC_W-1:0] fx_sum   = fx_acc_q + FX_STEP;
	wire             fx_wrap  = (fx_sum >= fx_limit);
	// realign only with feedback present, once per divisor source cycles
	wire             fx_align = src_rise & fb_present & (fx_dcnt_q == 6'h00);
	wire             fx_next  = fx_align ? 1'b1 : (fx_wrap ? ~fx_q : fx_q);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fx_acc_q  <= '0;
			fx_q      <= 1'b0;
			fx_dcnt_q <= 6'h00;
		end else begin
			fx_acc_q  <= fx_align ? '0 : (fx_wrap ? fx_sum - fx_limit : fx_sum);
			fx_q      <= fx_next;
			if (src_rise) begin
				fx_dcnt_q <= (fx_dcnt_q >= SYNTH_DIVISOR - 6'h01) ? 6'h00 : fx_dcnt_q + 6'h01;
			end
		end
	end

	// stopped watch: no synth edge for P*D core cycles, i.e. divisor source periods' worth
	// the bound is a full P*D, far above a half synth period, so
	// ordinary rounding jitter never trips the stopped flag
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fx_idle_q <= '0;
		end else if (fx_next != fx_q) begin
			fx_idle_q <= '0;
		end else if (fx_idle_q != {ACC_W{1'b1}}) begin
			fx_idle_q <= fx_idle_q + 24'h000001;
		end
	end

	wire fx_stopped = (fx_idle_q > fx_limit) & ~src_lost;

	// ==================================================
	// registered outputs; all clocks low while in reset
	// every output leaves a flop so that no decode glitch reaches a
	// pin; the cost is one extra core cycle of latency on all but the synth pair, which registers fx_next
	// spare status bits stay low so that software may test them later
	logic [STATUS_W-1:0] status_d;

	always_comb begin
		status_d                  = '0;
		status_d[ST_SRC_LOST_BIT] = src_lost & fb_present;
		status_d[ST_FX_STOP_BIT]  = fx_stopped;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			zero_phase_clk           <= 1'b0;
			double_rate_clk          <= 1'b0;
			double_rate_clk_inverted <= 1'b0;
			divided_clk              <= 1'b0;
			synth_clk                <= 1'b0;
			synth_clk_inverted       <= 1'b0;
			lock_indicator           <= 1'b0;
			status                   <= '0;
			startup_stall            <= 1'b0;
		end else begin
			zero_phase_clk           <= (ph_q < q2);
			double_rate_clk          <= dbl_on & (locked ? dbl_lock : dbl_pre);
			double_rate_clk_inverted <= dbl_on & locked & dbl_inv;
			divided_clk              <= dv_q;
			// range select is not wired to any logic; the same waveform logic serves either range
			synth_clk                <= fx_next;
			synth_clk_inverted       <= ~fx_next;
			lock_indicator           <= locked;
			status                   <= status_d;
			startup_stall            <= HOLD_STARTUP_FOR_LOCK &
			                            (startup_phase == LOCK_WAIT_PHASE) & ~locked;
		end
	end
endmodule

`default_nettype wire

// >>> cfs_pkg.sv
`default_nettype none
package cfs_pkg;
	// ==================================================
	// timing
	localparam int unsigned CORE_PERIOD_PS   = 4000;
	localparam int unsigned PERIOD_W         = 16;
	localparam int unsigned ACC_W            = 24;
	localparam logic [PERIOD_W-1:0] PERIOD_MAX = 16'hffff;
	// consecutive matching source periods (within PERIOD_TOL) needed before lock
	localparam logic [5:0]  LOCK_PERIODS     = 6'h10;
	// allowed jitter of a measured period, in core cycles
	localparam logic [PERIOD_W-1:0] PERIOD_TOL = 16'h0001;

	// ==================================================
	// defaults of the static settings
	localparam logic [5:0]  DIVIDE_HALVES_DEF = 6'h04;
	localparam logic [5:0]  MULT_DEF          = 6'h04;
	localparam logic [5:0]  DIV_DEF           = 6'h01;
	localparam int unsigned HINT_PS_DEF       = 40000;

	// ==================================================
	// status bus layout
	localparam int unsigned STATUS_W        = 8;
	localparam int unsigned ST_SRC_LOST_BIT = 1;
	localparam int unsigned ST_FX_STOP_BIT  = 2;

	// ==================================================
	// lock tracker
	typedef enum logic [2:0] {
		CFS_IDLE    = 3'b001,
		CFS_MEASURE = 3'b010,
		CFS_LOCKED  = 3'b100
	} cfs_lock_type;
endpackage
`default_nettype wire

// >>> cfs_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// port checker for the synthesis block
module cfs_top_sva
	import cfs_pkg::*;
#(
	parameter bit         LOOP_HIGH_RANGE       = 1'b0,
	parameter bit         HOLD_STARTUP_FOR_LOCK = 1'b0,
	parameter logic [2:0] LOCK_WAIT_PHASE       = 3'h6
) (
	input wire logic                core_clk,
	input wire logic                rstn,
	input wire logic [2:0]          startup_phase,
	input wire logic                double_rate_clk,
	input wire logic                double_rate_clk_inverted,
	input wire logic                divided_clk,
	input wire logic                synth_clk,
	input wire logic                synth_clk_inverted,
	input wire logic                lock_indicator,
	input wire logic [STATUS_W-1:0] status,
	input wire logic                startup_stall
);
	wire logic stall_cause;

	// phase part of the stall request; lock is compared as registered,
	// since lock and stall leave the block on the same edge
	assign stall_cause = HOLD_STARTUP_FOR_LOCK && startup_phase == LOCK_WAIT_PHASE;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// lock may lag the loss flag by the flag's own register
	sequence s_lock_gone;
		##[0:2] !lock_indicator;
	endsequence

	a_synth_pair_inverse: assert property ($past(rstn) |-> synth_clk_inverted == !synth_clk)
		else $error("synth outputs not complementary");
	a_status_spare_zero: assert property (status[7:3] == 5'h00 && !status[0])
		else $error("unused status bits active");
	a_release_all_low: assert property (!$past(rstn) |->
		!lock_indicator && !synth_clk && !divided_clk && status == 8'h00)
		else $error("outputs not idle out of reset");
	a_stall_follows_lock: assert property ($past(rstn) |->
		startup_stall == ($past(stall_cause) && !lock_indicator))
		else $error("startup stall wrong");
	a_wide_loop_no2x: assert property (LOOP_HIGH_RANGE |-> !double_rate_clk && !double_rate_clk_inverted)
		else $error("doubled clock in high range");
	a_prelock_inv_low: assert property (!lock_indicator && !$past(lock_indicator) |-> !double_rate_clk_inverted)
		else $error("inverted doubled clock before lock");
	a_loss_drops_lock: assert property ($rose(status[ST_SRC_LOST_BIT]) |-> s_lock_gone)
		else $error("lock kept after source loss");
	a_fx_stop_needs_src: assert property ($rose(status[ST_FX_STOP_BIT]) |-> !$past(status[ST_SRC_LOST_BIT]))
		else $error("synth stop flagged without source");
endmodule

bind cfs_top cfs_top_sva #(
	.LOOP_HIGH_RANGE       (LOOP_HIGH_RANGE),
	.HOLD_STARTUP_FOR_LOCK (HOLD_STARTUP_FOR_LOCK),
	.LOCK_WAIT_PHASE       (LOCK_WAIT_PHASE)
) i_cfs_top_sva (.core_clk, .rstn, .startup_phase, .double_rate_clk, .double_rate_clk_inverted,
	.divided_clk, .synth_clk, .synth_clk_inverted, .lock_indicator, .status, .startup_stall);
`default_nettype wire

// >>> cfs_src_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// user side: source clock maker and feedback loop
module cfs_src_model #(
	parameter int HALF = 8
) (
	input  wire logic core_clk,
	input  wire logic run,
	input  wire logic loop_fb,
	input  wire logic zero_phase_clk,
	output var  logic source_clk,
	output wire logic feedback_clk
);
	int cnt = 0;

	initial source_clk = 1'b0;

	// a stopped source parks low, as a dead oscillator would
	always @(posedge core_clk) begin
		if (!run || cnt == HALF - 1) begin
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
		if (!run) begin
			source_clk <= 1'b0;
		end else if (cnt == HALF - 1) begin
			source_clk <= !source_clk;
		end
	end

	// loop open means the feedback pin is grounded
	assign feedback_clk = loop_fb ? zero_phase_clk : 1'b0;
endmodule
`default_nettype wire

// >>> cfs_top_test.sv
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// bench
module cfs_top_test;
	import cfs_pkg::*;
	logic       core_clk      = 1'b0;
	logic       rstn          = 1'b0;
	logic       run           = 1'b1;
	logic       loop_fb       = 1'b0;
	logic [2:0] startup_phase = 3'h6;
	wire logic  src, fb, zp, d2, d2i, dv, fx, fxi, lk, sta, dvb, lkb, stb;
	wire logic [7:0] st;
	wire logic [9:0] obs;
	int num_errors = 0;
	int n_tests = 0;

	// index map used by the measuring tasks
	assign obs = {st[2], lkb, dvb, st[1], lk, fxi, fx, dv, d2i, d2};

	initial forever #2 core_clk = ~core_clk;

	// source period 16 cycles, hint given to match (64 ns)
	// default 4/1 synth ratio is already in lowest terms
	cfs_src_model i_cfs_src_model (.core_clk(core_clk), .run(run), .loop_fb(loop_fb),
		.zero_phase_clk(zp), .source_clk(src), .feedback_clk(fb));
	cfs_top #(.SOURCE_PERIOD_HINT_PS(64000)) i_cfs_top (.core_clk(core_clk), .rstn(rstn),
		.source_clk(src), .feedback_clk(fb), .startup_phase(startup_phase), .zero_phase_clk(zp),
		.double_rate_clk(d2), .double_rate_clk_inverted(d2i), .divided_clk(dv), .synth_clk(fx),
		.synth_clk_inverted(fxi), .lock_indicator(lk), .status(st), .startup_stall(sta));
	// ratio 1.5, wide loop, startup hold in the default wait phase, shared feedback
	cfs_top #(.DIVIDE_HALVES(6'h03), .LOOP_HIGH_RANGE(1'b1), .HOLD_STARTUP_FOR_LOCK(1'b1))
		i_cfs_top_b (.core_clk(core_clk), .rstn(rstn),
		.source_clk(src), .feedback_clk(fb), .startup_phase(startup_phase), .zero_phase_clk(),
		.double_rate_clk(), .double_rate_clk_inverted(), .divided_clk(dvb), .synth_clk(),
		.synth_clk_inverted(), .lock_indicator(lkb), .status(), .startup_stall(stb));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: seen %0d expected %0d", $time, seen, exp);
		end
	endtask

	// count high cycles and rises over a whole number of periods
	task automatic meas(input int idx, input int len, input int eh, input int er);
		int h;
		int r;
		logic p;
		h = 0;
		r = 0;
		// start from a settled sample, never the launching edge
		@(negedge core_clk);
		p = obs[idx];
		repeat (len) begin
			@(negedge core_clk);
			h += int'(obs[idx] === 1'b1);
			r += int'(obs[idx] === 1'b1 && p === 1'b0);
			p = obs[idx];
		end
		check(32'(h), 32'(eh));
		check(32'(r), 32'(er));
	endtask

	task automatic wait_for(input int idx, input logic v, input int max);
		int k;
		k = 0;
		while (obs[idx] !== v && k < max) begin
			@(negedge core_clk);
			k++;
		end
		check(32'(obs[idx]), 32'(v));
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// the first reset pulse spans one source period, the second four
	initial begin
		repeat (16) @(negedge core_clk);
		check(32'({obs, sta, stb}), 32'h0);
		@(posedge core_clk) rstn <= 1'b1;
		repeat (100) @(posedge core_clk);
		@(posedge zp);
		meas(0, 80, 20, 5);
		check(32'(stb), 32'h1);
		wait_for(5, 1'b1, 2000);
		wait_for(8, 1'b1, 2000);
		@(posedge zp);
		meas(0, 160, 80, 20);
		meas(1, 160, 80, 20);
		meas(2, 160, 80, 5);
		meas(3, 160, 80, 40);
		meas(4, 160, 80, 40);
		meas(7, 96, 48, 4);
		check(32'({sta, stb}), 32'h0);
		@(posedge core_clk) loop_fb <= 1'b1;
		repeat (100) @(posedge core_clk);
		run <= 1'b0;
		wait_for(6, 1'b1, 300);
		// lock leaves one core cycle after the loss flag
		repeat (2) @(negedge core_clk);
		check(32'({lk, st[2]}), 32'h0);
		@(posedge core_clk) run <= 1'b1;
		rstn <= 1'b0;
		repeat (64) @(negedge core_clk);
		check(32'(obs), 32'h0);
		@(posedge core_clk) rstn <= 1'b1;
		startup_phase <= 3'h5;
		repeat (3) @(negedge core_clk);
		check(32'(stb), 32'h0);
		@(posedge core_clk) startup_phase <= 3'h6;
		repeat (3) @(negedge core_clk);
		check(32'(stb), 32'h1);
		wait_for(5, 1'b1, 2000);
		@(posedge zp);
		meas(3, 160, 80, 40);
		@(posedge core_clk) loop_fb <= 1'b0;
		repeat (100) @(posedge core_clk);
		run <= 1'b0;
		repeat (300) @(negedge core_clk);
		check(32'(st[1]), 32'h0);
		tally_and_finish;
	end

	// the run needs under 4000 cycles; 20000 means a hang
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
